// ===== design/pmsm_core.sv
// Purpose: main power state machine of a multi-regulator power device
// Assumes: inputs synchronous to sys_clk_in; rst_in models the input supply below undervoltage
// Notes: sequence slot timing is abstracted to one slot per clock
//
// Summary of operation
// - quick-off select with no event: wait in quick off
// - quick off state allows mirror register access
// - trim, fuse or selftest error blocks power up
// - power up event loads fuse defaults into registers
// - enable regulators in order; reset release enters system-on
// - system-on allows host register read and write
// - after power up enter run, release processor reset
// - run and standby voltages load fuse value
// - sequenced regulator default mode: pwm or fuse choice
// - unsequenced regulator modes load off
// - every off-to-run restores fuse voltage defaults
// - standby pin with polarity invert selects standby
// - regulators disabled in standby turn off on entry
// - watchdog reset counts; at limit power down, fail-safe
// - below limit perform hard watchdog reset
// - watchdog from pin transition or internal expiry
// - power down ends: fault to fail-safe, else off
// - fail-safe entry sets one failure-source flag
// - failure flags held; host clears by writing one
// - fail-safe entry compares and increments fail-safe counter
// - bypass fuse goes off, else lock at limit
// - fail-safe state left only by supply cycle
// - system-on ok timer decrements fail-safe counter
`timescale 1ns/1ps
`default_nettype none

module pmsm_core
    import pmsm_pkg::*;
#(
    parameter int N_REGS = NUM_REGS,
    parameter logic [31:0] TICK_CYCLES_P = TICK_CYCLES_W
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // events and pins
    input wire logic powerup_event_in,
    input wire logic turnoff_event_in,
    input wire logic fault_turnoff_in,
    input wire logic powerup_fail_in,
    input wire logic regulator_fail_in,
    input wire logic thermal_fail_in,
    input wire logic standby_pin_in,
    input wire logic watchdog_input_pin_in,
    input wire logic watchdog_expiry_in,
    // configuration
    input wire logic quick_off_select_in,
    input wire logic standby_polarity_invert_in,
    input wire logic trim_load_error_flag_in,
    input wire logic fuse_load_error_flag_in,
    input wire logic selftest_error_flag_in,
    input wire logic [CNT_W-1:0] watchdog_event_limit_in,
    input wire logic [CNT_W-1:0] failsafe_limit_in,
    input wire logic failsafe_bypass_fuse_in,
    input wire logic [2:0] failsafe_ok_period_select_in,
    input wire logic fuse_sync_mode_in,
    input wire logic fuse_sync_output_enable_in,
    input wire logic fuse_spread_spectrum_enable_in,
    input wire logic fuse_default_mode_select_in,
    input wire logic [N_REGS*VOLT_W-1:0] fuse_voltage_value_in,
    input wire logic [N_REGS-1:0] in_sequence_in,
    input wire logic [N_REGS-1:0] standby_enable_in,
    // host register access
    input wire logic host_wr_in,
    input wire logic [$clog2(N_REGS)-1:0] host_reg_sel_in,
    input wire pmsm_reg_cfg_t host_wdata_in,
    input wire pmsm_fail_t fail_clear_in,
    input wire logic failsafe_counter_clear_in,
    // outputs
    output logic processor_reset_out,
    output logic [N_REGS-1:0] regulator_enable_out,
    output pmsm_reg_cfg_t [N_REGS-1:0] reg_cfg_out,
    output pmsm_state_t state_out,
    output pmsm_fail_t fail_flags_out,
    output logic [CNT_W-1:0] watchdog_event_counter_out,
    output logic [CNT_W-1:0] failsafe_counter_out,
    output logic mirror_access_out,
    output logic host_access_out
);

    pmsm_state_t state_reg;
    pmsm_state_t state_next;
    logic [SLOT_W-1:0] slot_reg;
    logic fault_reg;
    logic wd_cause_reg;
    logic wdi_prev_reg;
    logic [31:0] tick_reg;
    logic [15:0] sec_reg;
    logic [N_REGS-1:0] reset_slot_hit;
    logic wd_hit;
    logic standby_active;
    logic up_ok;
    logic sys_on;
    logic fs_entry;
    logic [CNT_W-1:0] wd_cnt_inc;
    logic [15:0] ok_seconds;

    function automatic logic [MODE_W-1:0] default_mode(input logic seq);
        if (!seq)
            default_mode = MODE_OFF;
        else if (fuse_sync_mode_in || fuse_sync_output_enable_in || fuse_spread_spectrum_enable_in)
            default_mode = MODE_PWM;
        else
            default_mode = fuse_default_mode_select_in ? MODE_PWM : MODE_AUTOSKIP;
    endfunction

    assign wd_hit = (watchdog_input_pin_in != wdi_prev_reg) || watchdog_expiry_in;
    assign standby_active = standby_pin_in ^ standby_polarity_invert_in;
    assign up_ok = powerup_event_in && !trim_load_error_flag_in && !fuse_load_error_flag_in
        && !selftest_error_flag_in;
    assign sys_on = (state_reg == PMSM_RUN) || (state_reg == PMSM_STANDBY);
    assign wd_cnt_inc = watchdog_event_counter_out + CNT_ONE;
    assign fs_entry = (state_next == PMSM_FS_TRANS) && (state_reg != PMSM_FS_TRANS);
    assign ok_seconds = 16'(MINUTES_TABLE[failsafe_ok_period_select_in] * SECONDS_PER_MINUTE);

    // one slot per regulator; the processor reset is released after the last slot, whether its regulator is sequenced or not
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PMSM_LOW_POWER_OFF_STATE:
            begin
                if (up_ok)
                    state_next = PMSM_POWER_UP;
                else if (quick_off_select_in && !powerup_event_in)
                    state_next = PMSM_QUICK_POWERUP_OFF_STATE;
            end
            PMSM_QUICK_POWERUP_OFF_STATE:
            begin
                if (up_ok)
                    state_next = PMSM_POWER_UP;
            end
            PMSM_POWER_UP:
            begin
                if (powerup_fail_in)
                    state_next = PMSM_PWR_DOWN;
                else if (slot_reg == SLOT_W'(N_REGS))
                    state_next = PMSM_RUN;
            end
            PMSM_RUN, PMSM_STANDBY:
            begin
                if (fault_turnoff_in || regulator_fail_in || thermal_fail_in || turnoff_event_in)
                    state_next = PMSM_PWR_DOWN;
                else if (wd_hit)
                    state_next = PMSM_WD_RESET;
                else
                    state_next = standby_active ? PMSM_STANDBY : PMSM_RUN;
            end
            PMSM_WD_RESET:
            begin
                if (watchdog_event_counter_out == watchdog_event_limit_in)
                    state_next = PMSM_PWR_DOWN;
                else
                    state_next = PMSM_POWER_UP;
            end
            PMSM_PWR_DOWN:
            begin
                if (regulator_enable_out == '0)
                    state_next = fault_reg ? PMSM_FS_TRANS : PMSM_LOW_POWER_OFF_STATE;
            end
            PMSM_FS_TRANS:
            begin
                if (failsafe_bypass_fuse_in || failsafe_counter_out != failsafe_limit_in)
                    state_next = PMSM_LOW_POWER_OFF_STATE;
                else
                    state_next = PMSM_FS_STATE;
            end
            PMSM_FS_STATE:
                state_next = PMSM_FS_STATE;
            default:
                state_next = PMSM_LOW_POWER_OFF_STATE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state_reg <= PMSM_LOW_POWER_OFF_STATE;
        else
            state_reg <= state_next;
    end

    // sequencing slot counter for power up
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            slot_reg <= SLOT_ZERO;
        else if (state_reg != PMSM_POWER_UP)
            slot_reg <= SLOT_ZERO;
        else if (slot_reg != SLOT_W'(N_REGS))
            slot_reg <= slot_reg + SLOT_W'(1);
    end

    // regulator enables: powered in order, dropped together by the down sequencer
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            regulator_enable_out <= '0;
        else
        begin
            for (int i = 0; i < N_REGS; i++)
            begin
                if (state_reg == PMSM_POWER_UP && slot_reg == SLOT_W'(i))
                    regulator_enable_out[i] <= in_sequence_in[i];
                else if (state_reg == PMSM_STANDBY)
                    regulator_enable_out[i] <= regulator_enable_out[i] & standby_enable_in[i];
                else if (state_reg == PMSM_RUN)
                    regulator_enable_out[i] <= regulator_enable_out[i] | in_sequence_in[i];
                else if (state_reg != PMSM_POWER_UP)
                    regulator_enable_out[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            processor_reset_out <= 1'b0;
        else
            processor_reset_out <= (state_next == PMSM_RUN) || (state_next == PMSM_STANDBY);
    end

    // fuse defaults replace host values on every entry to power up
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            reg_cfg_out <= '0;
        else
        begin
            for (int i = 0; i < N_REGS; i++)
            begin
                if (state_next == PMSM_POWER_UP && state_reg != PMSM_POWER_UP)
                begin
                    reg_cfg_out[i].run_voltage_reg <= fuse_voltage_value_in[i*VOLT_W +: VOLT_W];
                    reg_cfg_out[i].standby_voltage_reg <= fuse_voltage_value_in[i*VOLT_W +: VOLT_W];
                    reg_cfg_out[i].run_mode_field <= default_mode(in_sequence_in[i]);
                    reg_cfg_out[i].standby_mode_field <= default_mode(in_sequence_in[i]);
                end
                else if (sys_on && host_wr_in && host_reg_sel_in == i[$clog2(N_REGS)-1:0])
                    reg_cfg_out[i] <= host_wdata_in;
            end
        end
    end

    // fault origin of the current shutdown; the watchdog cause is latched, its counter outlives the event
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fault_reg <= 1'b0;
            wd_cause_reg <= 1'b0;
        end
        else if (state_reg != PMSM_PWR_DOWN && state_next == PMSM_PWR_DOWN)
        begin
            fault_reg <= (state_reg == PMSM_POWER_UP) || (state_reg == PMSM_WD_RESET)
                || fault_turnoff_in || regulator_fail_in || thermal_fail_in;
            wd_cause_reg <= state_reg == PMSM_WD_RESET;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            wdi_prev_reg <= 1'b0;
        else
            wdi_prev_reg <= watchdog_input_pin_in;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            watchdog_event_counter_out <= CNT_ZERO;
        else if (sys_on && state_next == PMSM_WD_RESET)
            watchdog_event_counter_out <= wd_cnt_inc;
    end

    // set wins over a same-cycle host clear
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            fail_flags_out <= '0;
        else
        begin
            if (sys_on)
                fail_flags_out <= fail_flags_out & ~fail_clear_in;
            if (fs_entry)
            begin
                if (wd_cause_reg)
                    fail_flags_out.watchdog <= 1'b1;
                else if (thermal_fail_in)
                    fail_flags_out.thermal <= 1'b1;
                else if (regulator_fail_in)
                    fail_flags_out.regulator <= 1'b1;
                else
                    fail_flags_out.powerup <= 1'b1;
            end
        end
    end

    // one-second tick then second count up to the ok period
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_reg <= '0;
            sec_reg <= '0;
        end
        else if (!sys_on)
        begin
            tick_reg <= '0;
            sec_reg <= '0;
        end
        else if (tick_reg == TICK_CYCLES_P - 32'h1)
        begin
            tick_reg <= '0;
            sec_reg <= (sec_reg >= ok_seconds - 16'h1) ? 16'h0 : sec_reg + 16'h1;
        end
        else
            tick_reg <= tick_reg + 32'h1;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            failsafe_counter_out <= CNT_ZERO;
        else if (fs_entry && failsafe_counter_out != failsafe_limit_in)
            failsafe_counter_out <= failsafe_counter_out + CNT_ONE;
        else if (sys_on && failsafe_counter_clear_in)
            failsafe_counter_out <= CNT_ZERO;
        else if (sys_on && tick_reg == TICK_CYCLES_P - 32'h1 && sec_reg >= ok_seconds - 16'h1
            && failsafe_counter_out != CNT_ZERO)
            failsafe_counter_out <= failsafe_counter_out - CNT_ONE;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_out <= PMSM_LOW_POWER_OFF_STATE;
            mirror_access_out <= 1'b0;
            host_access_out <= 1'b0;
        end
        else
        begin
            state_out <= state_next;
            mirror_access_out <= state_next == PMSM_QUICK_POWERUP_OFF_STATE;
            host_access_out <= (state_next == PMSM_RUN) || (state_next == PMSM_STANDBY);
        end
    end

    chk_qpu_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_QUICK_POWERUP_OFF_STATE && !powerup_event_in |=> state_reg == PMSM_QUICK_POWERUP_OFF_STATE)
        else $error("quick off left without event");
    chk_error_blocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_QUICK_POWERUP_OFF_STATE && fuse_load_error_flag_in |=> state_reg != PMSM_POWER_UP)
        else $error("power up despite fuse error");
    chk_reset_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_RUN |-> processor_reset_out)
        else $error("reset held in run");
    chk_standby_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_RUN && !wd_hit && !turnoff_event_in && !fault_turnoff_in && !regulator_fail_in
        && !thermal_fail_in && standby_active |=> state_reg == PMSM_STANDBY)
        else $error("standby not entered");
    chk_wd_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_RUN && state_next == PMSM_WD_RESET |=>
        watchdog_event_counter_out == $past(watchdog_event_counter_out) + CNT_ONE)
        else $error("watchdog count missed");
    chk_fs_lock: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_FS_STATE |=> state_reg == PMSM_FS_STATE)
        else $error("fail-safe state left");
    chk_bypass: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_FS_TRANS && failsafe_bypass_fuse_in |=> state_reg == PMSM_LOW_POWER_OFF_STATE)
        else $error("bypass not honoured");
    chk_fault_path: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == PMSM_PWR_DOWN && regulator_enable_out == '0 && !fault_reg |=> state_reg == PMSM_LOW_POWER_OFF_STATE)
        else $error("clean power down not to off");

endmodule

`default_nettype wire

// ===== design/pmsm_pkg.sv
// Purpose: shared constants and types of the power state machine
// Assumes: 100 MHz system clock
// Notes: the fail-safe period counts are large, the top module takes a scaler parameter
package pmsm_pkg;

    localparam int SYS_CLK_HZ = 100000000;
    localparam int NUM_REGS = 4;
    localparam int CNT_W = 4;
    localparam int VOLT_W = 8;
    localparam int MODE_W = 2;
    localparam int SLOT_W = 4;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    localparam logic [1:0] MODE_AUTOSKIP = 2'h3;

    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_ZERO = 4'h0;

    // fail-safe ok period in minutes, indexed by the period select
    localparam int MINUTES_TABLE [8] = '{1, 5, 10, 15, 20, 30, 45, 60};
    localparam int SECONDS_PER_MINUTE = 60;
    localparam int TICK_PERIOD_US = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_US / 1000000 * SYS_CLK_HZ;
    localparam logic [31:0] TICK_CYCLES_W = 32'(TICK_CYCLES);

    typedef enum logic [8:0] {
        PMSM_LOW_POWER_OFF_STATE = 9'h001,
        PMSM_QUICK_POWERUP_OFF_STATE = 9'h002,
        PMSM_POWER_UP = 9'h004,
        PMSM_RUN = 9'h008,
        PMSM_STANDBY = 9'h010,
        PMSM_PWR_DOWN = 9'h020,
        PMSM_FS_TRANS = 9'h040,
        PMSM_FS_STATE = 9'h080,
        PMSM_WD_RESET = 9'h100
    } pmsm_state_t;

    typedef struct packed {
        logic powerup;
        logic watchdog;
        logic regulator;
        logic thermal;
    } pmsm_fail_t;

    typedef struct packed {
        logic [VOLT_W-1:0] run_voltage_reg;
        logic [VOLT_W-1:0] standby_voltage_reg;
        logic [MODE_W-1:0] run_mode_field;
        logic [MODE_W-1:0] standby_mode_field;
    } pmsm_reg_cfg_t;

endpackage

// ===== verif/pmsm_host_model.sv
// Purpose: host processor model driving the standby and watchdog pins
// Assumes: pins move only while the processor is released from reset
// Notes: the bench orders sleep and kicks; the model owns pin levels
`timescale 1ns/1ps
`default_nettype none
module pmsm_host_model
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // bench orders
    input wire logic sleep_req_in,
    input wire logic kick_req_in,
    input wire logic invert_in,
    // processor state
    input wire logic processor_reset_in,
    // pins
    output logic standby_pin_out,
    output logic watchdog_pin_out
);
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            standby_pin_out <= invert_in;
            watchdog_pin_out <= 1'b0;
        end
        else if (processor_reset_in)
        begin
            // a processor held in reset cannot move its pins
            standby_pin_out <= sleep_req_in ^ invert_in;
            if (kick_req_in)
            begin
                watchdog_pin_out <= ~watchdog_pin_out;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench of the power state machine
// Assumes: ok timer scaled to 4 cycles per second
// Notes: waits are bounded; a lapsed wait ends the run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmsm_pkg::*;
    localparam int NR = 4;
    logic sys_clk_in, rst_in, pu_ev, off_ev, thf, wexp, qoff, inv, byp, sync, sout, fss, dm;
    logic hwr, sleep, kick, prst, mir, hacc, sbp, wdp, pfail;
    logic [2:0] errs;
    logic [3:0] wdl, fsl, seq, sben, ren, wdc, fsc;
    logic [1:0] hsel;
    logic [31:0] fv, seed;
    pmsm_reg_cfg_t hwd;
    pmsm_fail_t fclr, ff;
    pmsm_reg_cfg_t [NR-1:0] cfg;
    pmsm_state_t st;
    int bad_count, tests_run;

    pmsm_host_model host (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sleep_req_in(sleep), .kick_req_in(kick),
        .invert_in(inv), .processor_reset_in(prst), .standby_pin_out(sbp), .watchdog_pin_out(wdp));

    pmsm_core #(.N_REGS(NR), .TICK_CYCLES_P(32'h4)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .powerup_event_in(pu_ev), .turnoff_event_in(off_ev), .fault_turnoff_in(1'b0), .powerup_fail_in(pfail),
        .regulator_fail_in(1'b0), .thermal_fail_in(thf), .standby_pin_in(sbp), .watchdog_input_pin_in(wdp),
        .watchdog_expiry_in(wexp), .quick_off_select_in(qoff), .standby_polarity_invert_in(inv),
        .trim_load_error_flag_in(errs[0]), .fuse_load_error_flag_in(errs[1]), .selftest_error_flag_in(errs[2]),
        .watchdog_event_limit_in(wdl), .failsafe_limit_in(fsl), .failsafe_bypass_fuse_in(byp),
        .failsafe_ok_period_select_in(3'h0), .fuse_sync_mode_in(sync), .fuse_sync_output_enable_in(sout),
        .fuse_spread_spectrum_enable_in(fss), .fuse_default_mode_select_in(dm), .fuse_voltage_value_in(fv),
        .in_sequence_in(seq), .standby_enable_in(sben), .host_wr_in(hwr), .host_reg_sel_in(hsel),
        .host_wdata_in(hwd), .fail_clear_in(fclr), .failsafe_counter_clear_in(1'b0),
        .processor_reset_out(prst), .regulator_enable_out(ren), .reg_cfg_out(cfg), .state_out(st),
        .fail_flags_out(ff), .watchdog_event_counter_out(wdc), .failsafe_counter_out(fsc),
        .mirror_access_out(mir), .host_access_out(hacc));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // any pwm forcing bit wins over the default-mode fuse
    function automatic pmsm_reg_cfg_t exp_cfg(input int i);
        pmsm_reg_cfg_t c;
        logic [1:0] m;
        m = (sync | sout | fss | dm) ? MODE_PWM : MODE_AUTOSKIP;
        if (!seq[i])
            m = MODE_OFF;
        c.run_voltage_reg = fv[i*8+:8];
        c.standby_voltage_reg = fv[i*8+:8];
        c.run_mode_field = m;
        c.standby_mode_field = m;
        return c;
    endfunction

    task automatic finish_test;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // inputs land one step after the edge, outputs are read settled
    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge sys_clk_in);
            #1;
        end
    endtask

    task automatic wait_st(input pmsm_state_t s);
        int k;
        k = 0;
        while (st !== s && k < 400)
        begin
            cyc(1);
            k++;
        end
        if (st !== s)
        begin
            bad_count++;
            $display("[FAIL] state wait expected %0h seen %0h", s, st);
            finish_test();
        end
    endtask

    task automatic power_up;
        pu_ev <= 1'b1;
        wait_st(PMSM_POWER_UP);
        pu_ev <= 1'b0;
        wait_st(PMSM_RUN);
        chk("processor reset", 32'h1, prst);
        chk("host access", 32'h1, hacc);
        chk("regulator enables", seq, ren);
    endtask

    initial
    begin
        {pu_ev, off_ev, thf, wexp, qoff, byp, sync, sout, fss, dm, hwr, sleep, kick, pfail} = '0;
        {errs, hsel, hwd, fclr} = '0;
        seed = 32'h2F79;
        inv = seed[3];
        wdl = 4'h2;
        fsl = 4'h1;
        fv = seed;
        seq = 4'hF;
        sben = 4'h0;
        bad_count = 0;
        tests_run = 0;
        rst_in = 1'b1;
        cyc(20);
        rst_in <= 1'b0;
        cyc(1);
        chk("state after reset", PMSM_LOW_POWER_OFF_STATE, st);
        chk("flags after reset", 32'h0, ff);
        qoff <= 1'b1;
        wait_st(PMSM_QUICK_POWERUP_OFF_STATE);
        chk("mirror access", 32'h1, mir);
        for (int e = 0; e < 3; e++)
        begin
            errs <= 3'h1 << e;
            pu_ev <= 1'b1;
            cyc(10);
            chk("error blocks power up", PMSM_QUICK_POWERUP_OFF_STATE, st);
            pu_ev <= 1'b0;
            errs <= 3'h0;
            cyc(1);
        end
        $display("test quick off done");
        // every mix of mode fuses, fresh random voltages each pass
        for (int c = 0; c < 16; c++)
        begin
            seed = lfsr(seed);
            {sync, sout, fss, dm} <= 4'(c);
            fv <= seed;
            seq <= seed[7:4];
            sben <= seed[11:8];
            cyc(1);
            power_up();
            for (int i = 0; i < NR; i++)
                chk("default config", exp_cfg(i), cfg[i]);
            seed = lfsr(seed);
            hsel <= seed[1:0];
            hwd <= seed[19:0];
            hwr <= 1'b1;
            cyc(1);
            hwr <= 1'b0;
            cyc(2);
            chk("host write", seed[19:0], cfg[seed[1:0]]);
            off_ev <= 1'b1;
            wait_st(PMSM_PWR_DOWN);
            off_ev <= 1'b0;
            wait_st(PMSM_QUICK_POWERUP_OFF_STATE);
        end
        $display("test power cycles done");
        power_up();
        sleep <= 1'b1;
        wait_st(PMSM_STANDBY);
        cyc(NR + 2);
        chk("standby enables", 32'h0, ren & ~sben);
        sleep <= 1'b0;
        wait_st(PMSM_RUN);
        $display("test standby done");
        byp <= 1'b1;
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        wait_st(PMSM_WD_RESET);
        wait_st(PMSM_RUN);
        chk("watchdog count", 32'h1, wdc);
        wexp <= 1'b1;
        cyc(1);
        wexp <= 1'b0;
        wait_st(PMSM_FS_TRANS);
        chk("watchdog flag", 32'h4, ff);
        wait_st(PMSM_QUICK_POWERUP_OFF_STATE);
        chk("watchdog count at limit", 32'h2, wdc);
        chk("fail-safe count", 32'h1, fsc);
        $display("test watchdog done");
        // a failed power up is a fault: fail-safe transition with the counter already at its limit
        pfail <= 1'b1;
        pu_ev <= 1'b1;
        wait_st(PMSM_POWER_UP);
        pu_ev <= 1'b0;
        wait_st(PMSM_FS_TRANS);
        chk("power up flag", 32'hC, ff);
        pfail <= 1'b0;
        wait_st(PMSM_QUICK_POWERUP_OFF_STATE);
        chk("fail-safe count held", 32'h1, fsc);
        $display("test power up failure done");
        power_up();
        chk("flag kept", 32'hC, ff);
        fclr <= 4'hC;
        cyc(1);
        fclr <= 4'h0;
        cyc(2);
        chk("flag cleared", 32'h0, ff);
        // one minute is 240 cycles at the scaled tick
        cyc(300);
        chk("ok timer decrement", 32'h0, fsc);
        $display("test flags done");
        byp <= 1'b0;
        thf <= 1'b1;
        wait_st(PMSM_FS_STATE);
        chk("thermal flag", 32'h1, ff);
        thf <= 1'b0;
        pu_ev <= 1'b1;
        cyc(20);
        chk("fail-safe lock", PMSM_FS_STATE, st);
        pu_ev <= 1'b0;
        qoff <= 1'b0;
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        cyc(2);
        chk("supply cycle exit", PMSM_LOW_POWER_OFF_STATE, st);
        $display("test fail-safe done");
        finish_test();
    end
endmodule
`default_nettype wire
